// *** logic/keypad_matrix_interface.sv ***
// Keypad matrix interface: row debouncing, press/release events, column drive, registers
//
// Summary of operation
// - Up to eight row inputs and eight column outputs serve a key matrix.
// - A detected press or release raises the interrupt request to the processor.
// - Status bits record press, release, or both when both conditions are enabled.
// - Every row passes a debounce filter before any event is recognised.
// - A row level must hold for two filter clock ticks to be accepted.
// - The key event source is the AND of all filtered rows.
// - Control register is read/write and resets to zero.
// - Status register reports events, clears them, and resets to zero.
// - Column register is read/write, resetting with bits 15 to 8 set.
// - Row register is read-only and returns the current row pin levels.
// - Divider register is read/write, resets to zero, sets the filter rate.
//
// Added by the designer: the strobed register port.
module keypad_matrix_interface
#(
  parameter int NUM_ROWS = 8,
  parameter int NUM_COLS = 8,
  parameter int DIV_W    = 16
) (
  input  wire logic                CLK_SYS,
  input  wire logic                RST,
  input  wire logic [31:0]         ADDR,
  input  wire logic [31:0]         WDATA,
  input  wire logic                WR,
  input  wire logic                RD,
  output logic      [31:0]         RDATA,
  input  wire logic [NUM_ROWS-1:0] ROW_IN,
  output logic      [NUM_COLS-1:0] COL_OUT,
  output logic      [NUM_COLS-1:0] COL_OE,
  output logic                     IRQ
);
  import keypad_pkg::*;

  // Elaboration checks: line counts and divider width the logic can serve
  if (NUM_ROWS < 1 || NUM_ROWS > MAX_LINES) begin : g_bad_rows
    $error("NUM_ROWS must lie in 1..8");
  end
  if (NUM_COLS < 1 || NUM_COLS > MAX_LINES) begin : g_bad_cols
    $error("NUM_COLS must lie in 1..8");
  end
  if (DIV_W < 1 || DIV_W > 32) begin : g_bad_div
    $error("DIV_W must lie in 1..32");
  end

  // The two-bit stability counter cannot reach a settle count beyond three
  if (FILTER_TICKS < 1 || FILTER_TICKS > 3) begin : g_bad_ticks
    $error("FILTER_TICKS must lie in 1..3");
  end

  // A narrower divider could never slow the filter clock down to its nominal rate
  if (DIV_W < $clog2(CLK_SYS_MHZ * 1000 / DEBOUNCE_FILTER_CLOCK_KHZ)) begin : g_short_div
    $error("DIV_W too narrow for the nominal filter clock");
  end

  // Address match used by the write strobe and status read decodes
  function automatic logic hit(input logic [31:0] a, input logic [31:0] off);
    hit = (a == off);
  endfunction

  // Widen an event pair into a bus word
  function automatic logic [31:0] evt_word(input evt_t e);
    evt_word = {{(32 - EVT_W){1'b0}}, e};
  endfunction

  // Control and mask registers, only the two event bits are stored
  ctrl_t              ctrl_r;
  evt_t               mask_r;

  // Sticky status and its next value
  evt_t               status_r;
  evt_t               status_nxt;

  // Column drive and filter ratio registers
  logic [15:0]        column_r;
  logic [DIV_W-1:0]   divider_r;

  // Word of the addressed register, registered onto the bus
  logic [31:0]        rdata_nxt;

  // Filter clock divider state
  logic [DIV_W-1:0]   div_cnt_r;
  logic               flt_tick;

  // Debounce state per row
  logic [NUM_ROWS-1:0] row_filt_r;
  logic [NUM_ROWS-1:0] row_cnt_r [2];
  logic [NUM_ROWS-1:0] row_cnt_nxt [2];

  // Tracker of the row AND: waiting out reset, all rows idle, some key down
  typedef enum logic [1:0] {
    st_wait = 2'b00,
    st_idle = 2'b01,
    st_down = 2'b10
  } trk_state_t;

  // Event detection state
  logic        all_high;
  trk_state_t  trk_r;
  trk_state_t  trk_nxt;
  evt_t        evt_now;
  logic        irq_nxt;

  // Bus strobes decoded per register; the row register has no write strobe
  logic wr_control;
  logic wr_status;
  logic wr_column;
  logic wr_divider;
  logic wr_mask;
  logic rd_status;

  assign wr_control = WR && hit(ADDR, OFF_CONTROL);
  assign wr_status  = WR && hit(ADDR, OFF_STATUS);
  assign wr_column  = WR && hit(ADDR, OFF_COLUMN);
  assign wr_divider = WR && hit(ADDR, OFF_DIVIDER);
  assign wr_mask    = WR && hit(ADDR, OFF_IRQ_MASK);
  assign rd_status  = RD && hit(ADDR, OFF_STATUS);

  // Control register, only the two enable bits are stored
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      ctrl_r <= ctrl_t'(RST_CONTROL[EVT_W-1:0]);
    end else if (wr_control) begin
      ctrl_r <= ctrl_t'(WDATA[EVT_W-1:0]);
    end
  end

  // Interrupt mask register, one bit per status bit
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      mask_r <= evt_t'(RST_IRQ_MASK[EVT_W-1:0]);
    end else if (wr_mask) begin
      mask_r <= evt_t'(WDATA[EVT_W-1:0]);
    end
  end

  // Column register: low byte drive values, high byte drive disables
  // Disables rather than enables keep every column quiet out of reset
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      column_r <= RST_COLUMN[15:0];
    end else if (wr_column) begin
      column_r <= WDATA[15:0];
    end
  end

  // Pins follow the register; reset leaves every column undriven
  assign COL_OUT = column_r[COL_DATA_LSB +: NUM_COLS];
  assign COL_OE  = ~column_r[COL_DIS_LSB +: NUM_COLS];

  // Divider register sets the filter clock ratio
  // Ratio is value plus one, so zero still gives a usable full-rate tick
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      divider_r <= RST_DIVIDER[DIV_W-1:0];
    end else if (wr_divider) begin
      divider_r <= WDATA[DIV_W-1:0];
    end
  end

  // Filter tick once every divider+1 system clocks
  assign flt_tick = (div_cnt_r >= divider_r);

  // Divider counter; a smaller new ratio restarts on the next compare
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      div_cnt_r <= '0;
    end else if (flt_tick) begin
      div_cnt_r <= '0;
    end else begin
      div_cnt_r <= div_cnt_r + 1'b1;
    end
  end

  // Stability counter per row, two bits wide, counted in filter ticks
  // Any return to the accepted level restarts the count at once
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      row_cnt_nxt[i] = row_cnt_r[i];
    end
    for (int r = 0; r < NUM_ROWS; r++) begin
      if (ROW_IN[r] == row_filt_r[r]) begin
        row_cnt_nxt[0][r] = 1'b0;
        row_cnt_nxt[1][r] = 1'b0;
      end else if (flt_tick) begin
        {row_cnt_nxt[1][r], row_cnt_nxt[0][r]} =
          2'({row_cnt_r[1][r], row_cnt_r[0][r]} + 2'h1);
      end
    end
  end

  // Counter storage; a glitch spanning fewer than FILTER_TICKS ticks never reaches the accept count
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      row_cnt_r[0] <= '0;
      row_cnt_r[1] <= '0;
    end else begin
      row_cnt_r[0] <= row_cnt_nxt[0];
      row_cnt_r[1] <= row_cnt_nxt[1];
    end
  end

  // Filtered rows accept a new level after FILTER_TICKS stable ticks
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      row_filt_r <= '1;
    end else begin
      for (int r = 0; r < NUM_ROWS; r++) begin
        if ({row_cnt_nxt[1][r], row_cnt_nxt[0][r]} == 2'(FILTER_TICKS)) begin
          row_filt_r[r] <= ROW_IN[r];
        end
      end
    end
  end

  // Rows idle high; any pressed key pulls the AND low
  assign all_high = &row_filt_r;

  // Falling AND is a press, rising AND is a release, each when enabled
  // The wait state only learns the level, so reset never fakes an event
  always_comb begin
    trk_nxt = trk_r;
    evt_now = '0;
    case (trk_r)
      st_wait: begin
        trk_nxt = all_high ? st_idle : st_down;
      end
      st_idle: begin
        if (!all_high) begin
          trk_nxt         = st_down;
          evt_now.pressed = ctrl_r.press_en;
        end
      end
      st_down: begin
        if (all_high) begin
          trk_nxt          = st_idle;
          evt_now.released = ctrl_r.release_en;
        end
      end
      default: begin
        trk_nxt = st_wait;
      end
    endcase
  end

  // Tracker state
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      trk_r <= st_wait;
    end else begin
      trk_r <= trk_nxt;
    end
  end

  // Status: read or write-one clears, a new event in that cycle wins
  // Losing an event to a racing clear would hide a key from software
  always_comb begin
    status_nxt = status_r;
    if (rd_status) begin
      status_nxt = '0;
    end else if (wr_status) begin
      status_nxt = status_r & ~evt_t'(WDATA[EVT_W-1:0]);
    end
    status_nxt = status_nxt | evt_now;
  end

  // Sticky status bits
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      status_r <= evt_t'(RST_STATUS[EVT_W-1:0]);
    end else begin
      status_r <= status_nxt;
    end
  end

  // Interrupt taken from the next status, so it rises with the sticky bit
  assign irq_nxt = |(status_nxt & mask_r);

  // Level interrupt while any unmasked status bit is set
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= irq_nxt;
    end
  end

  // Read mux; unmapped addresses return zero
  always_comb begin
    rdata_nxt = '0;
    case (ADDR)
      OFF_CONTROL: begin
        rdata_nxt = evt_word(evt_t'(ctrl_r));
      end
      OFF_STATUS: begin
        rdata_nxt = evt_word(status_r);
      end
      OFF_COLUMN: begin
        rdata_nxt = {16'h0000, column_r};
      end
      OFF_ROW: begin
        rdata_nxt = 32'(ROW_IN);
      end
      OFF_DIVIDER: begin
        rdata_nxt = 32'(divider_r);
      end
      OFF_IRQ_MASK: begin
        rdata_nxt = evt_word(mask_r);
      end
      default: begin
        rdata_nxt = '0;
      end
    endcase
  end

  // Read data stand for one cycle after the strobe, zero otherwise
  // Zero between reads lets several slaves share an OR-ed return bus
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      RDATA <= '0;
    end else if (RD) begin
      RDATA <= rdata_nxt;
    end else begin
      RDATA <= '0;
    end
  end

  // Software scans the columns itself through the column and row registers
  // Row readback is raw, so a scan sees the pins without filter delay
  // The hardware only flags that some key changed; finding it is software work

endmodule

// *** logic/keypad_pkg.sv ***
// Package with register map, field layout and timing constants of the keypad interface
package keypad_pkg;

  // Register byte addresses
  localparam logic [31:0] OFF_CONTROL  = 32'h7e00a000;
  localparam logic [31:0] OFF_STATUS   = 32'h7e00a004;
  localparam logic [31:0] OFF_COLUMN   = 32'h7e00a008;
  localparam logic [31:0] OFF_ROW      = 32'h7e00a00c;
  localparam logic [31:0] OFF_DIVIDER  = 32'h7e00a010;
  localparam logic [31:0] OFF_IRQ_MASK = 32'h7e00a014;

  // Reset values
  localparam logic [31:0] RST_CONTROL  = 32'h00000000;
  localparam logic [31:0] RST_STATUS   = 32'h00000000;
  localparam logic [31:0] RST_COLUMN   = 32'h0000ff00;
  localparam logic [31:0] RST_DIVIDER  = 32'h00000000;
  localparam logic [31:0] RST_IRQ_MASK = 32'h00000000;

  // Field positions in control, status and mask registers
  localparam int BIT_PRESS   = 0;
  localparam int BIT_RELEASE = 1;
  localparam int EVT_W       = 2;

  // Column register layout: drive values low, drive disables high
  localparam int COL_DATA_LSB = 0;
  localparam int COL_DIS_LSB  = 8;
  localparam int MAX_LINES    = 8;

  // Debounce time, in filter clock units
  localparam int DEBOUNCE_FILTER_CLOCK_KHZ    = 32;
  localparam int FILTER_TIME_NS = 62500;
  localparam int FILTER_TICKS   = (FILTER_TIME_NS * DEBOUNCE_FILTER_CLOCK_KHZ) / 1000000;

  // System clock
  localparam int CLK_SYS_MHZ = 125;

  // Control fields
  typedef struct packed {
    logic release_en;
    logic press_en;
  } ctrl_t;

  // Event pair, same layout as status and mask
  typedef struct packed {
    logic released;
    logic pressed;
  } evt_t;

endpackage

// *** sim/key_matrix_model.sv ***
// Passive key switch matrix with pulled-up row lines
module key_matrix_model (
  input  wire logic [7:0]  col_out,
  input  wire logic [7:0]  col_oe,
  input  wire logic [63:0] keys,
  output logic      [7:0]  row_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // A closed key pulls its row low only through a column driven low, else pull-up wins
  always_comb begin
    for (int r = 0; r < 8; r++) begin
      row_in[r] = !(|(keys[r*8 +: 8] & col_oe & ~col_out));
    end
  end
endmodule

// *** sim/keypad_matrix_interface_assertions.sv ***
// Checker of register bus, column drive and interrupt behaviour at the keypad ports
module keypad_checker
  import keypad_pkg::*;
#(
  parameter int NUM_ROWS = 8,
  parameter int NUM_COLS = 8,
  parameter int DIV_W    = 16
) (
  input wire logic                CLK_SYS,
  input wire logic                RST,
  input wire logic [31:0]         ADDR,
  input wire logic [31:0]         WDATA,
  input wire logic                WR,
  input wire logic                RD,
  input wire logic [31:0]         RDATA,
  input wire logic [NUM_ROWS-1:0] ROW_IN,
  input wire logic [NUM_COLS-1:0] COL_OUT,
  input wire logic [NUM_COLS-1:0] COL_OE,
  input wire logic                IRQ
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  localparam logic [31:0] DMASK = (DIV_W >= 32) ? '1 : (32'h1 << DIV_W) - 32'h1;
  // Address hits one of the mapped words
  wire logic mapped = ADDR inside {OFF_CONTROL, OFF_STATUS, OFF_COLUMN, OFF_ROW,
                                   OFF_DIVIDER, OFF_IRQ_MASK};

  // Read data stands only in the cycle after a read
  property p_rdata_idle;
    !RD |=> RDATA == 32'h0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read");
  property p_unmapped;
    RD && !mapped |=> RDATA == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_row_read;
    RD && ADDR == OFF_ROW |=> RDATA == 32'($past(ROW_IN));
  endproperty
  a_row_read: assert property (p_row_read) else $error("row readback wrong");
  property p_col_write;
    WR && ADDR == OFF_COLUMN |=> COL_OUT == NUM_COLS'($past(WDATA[7:0]))
      && COL_OE == NUM_COLS'(~$past(WDATA[15:8]));
  endproperty
  a_col_write: assert property (p_col_write) else $error("column drive wrong");
  property p_ctrl_rb;
    WR && ADDR == OFF_CONTROL ##1 RD && ADDR == OFF_CONTROL
      |=> RDATA == ($past(WDATA, 2) & 32'h3);
  endproperty
  a_ctrl_rb: assert property (p_ctrl_rb) else $error("control readback wrong");
  property p_div_rb;
    WR && ADDR == OFF_DIVIDER ##1 RD && ADDR == OFF_DIVIDER
      |=> RDATA == ($past(WDATA, 2) & DMASK);
  endproperty
  a_div_rb: assert property (p_div_rb) else $error("divider readback wrong");
  // Masking everything silences the interrupt once the new mask is in use
  property p_mask_quiet;
    WR && ADDR == OFF_IRQ_MASK && WDATA[1:0] == 2'b00 ##1 !(WR && ADDR == OFF_IRQ_MASK)
      |=> !IRQ;
  endproperty
  a_mask_quiet: assert property (p_mask_quiet) else $error("masked interrupt high");
  property p_read_clears;
    RD && ADDR == OFF_STATUS ##1 RD && ADDR == OFF_STATUS
      |=> (RDATA & $past(RDATA)) == 32'h0;
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("status not cleared");
endmodule

bind keypad_matrix_interface keypad_checker #(
  .NUM_ROWS(NUM_ROWS), .NUM_COLS(NUM_COLS), .DIV_W(DIV_W)
) i_keypad_checker (
  .CLK_SYS(CLK_SYS), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
  .RDATA(RDATA), .ROW_IN(ROW_IN), .COL_OUT(COL_OUT), .COL_OE(COL_OE), .IRQ(IRQ)
);

// *** sim/tb.sv ***
// Self-checking bench of the keypad matrix interface
module tb;
  import keypad_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys = 1'b0;
  logic        rst     = 1'b1;
  logic [31:0] addr    = '0;
  logic [31:0] wdata   = '0;
  logic        wr      = 1'b0;
  logic        rd      = 1'b0;
  logic [31:0] rdata;
  logic [7:0]  row_in, col_out, col_oe;
  logic        irq;
  logic [63:0] keys    = '0;
  logic [31:0] col_w, v;
  logic [31:0] amap [6] = '{OFF_CONTROL, OFF_STATUS, OFF_COLUMN, OFF_DIVIDER,
                            OFF_IRQ_MASK, OFF_IRQ_MASK + 32'h4};
  logic [31:0] rvals [6] = '{RST_CONTROL, RST_STATUS, RST_COLUMN, RST_DIVIDER,
                             RST_IRQ_MASK, 32'h0};
  int          failures = 0, num_checks = 0, seed = 66610, n, d, k;

  always #4 clk_sys = ~clk_sys;

  keypad_matrix_interface i_keypad_matrix_interface (
    .CLK_SYS(clk_sys), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .ROW_IN(row_in), .COL_OUT(col_out), .COL_OE(col_oe), .IRQ(irq));
  key_matrix_model i_key_matrix_model (
    .col_out(col_out), .col_oe(col_oe), .keys(keys), .row_in(row_in));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Bus tasks launch just after an edge so back-to-back strobes never collide
  task automatic wr_reg(input logic [31:0] a, input logic [31:0] dd);
    addr <= a;
    wdata <= dd;
    wr <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
    #1;
  endtask
  task automatic rd_reg(input logic [31:0] a, output logic [31:0] q);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1;
    q = rdata;
  endtask
  task automatic idle(input int c);
    repeat (c) @(posedge clk_sys);
    #1;
  endtask
  task automatic wait_irq(input int lim, output int cnt);
    cnt = 0;
    while (irq !== 1'b1 && cnt < lim) begin
      @(posedge clk_sys);
      #1;
      cnt++;
    end
  endtask
  // Rows seen through the pulled-up matrix for a given column word
  function automatic logic [31:0] rows_exp(input logic [63:0] kk, input logic [31:0] c);
    rows_exp = 32'h0;
    for (int r = 0; r < 8; r++) rows_exp[r] = !(|(kk[r*8 +: 8] & ~c[15:8] & ~c[7:0]));
  endfunction
  function automatic logic [31:0] rb_exp(input logic [31:0] a, input logic [31:0] dd);
    case (a)
      OFF_CONTROL, OFF_IRQ_MASK: rb_exp = dd & 32'h3;
      OFF_COLUMN, OFF_DIVIDER:   rb_exp = dd & 32'hffff;
      default:                   rb_exp = 32'h0;
    endcase
  endfunction
  task automatic end_of_test;
    if (failures == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    idle(1);
    chk({24'h0, col_oe}, 32'h0);
    for (int i = 0; i < 6; i++) begin
      rd_reg(amap[i], v);
      chk(v, rvals[i]);
    end
    // Random writes with immediate readback, one unmapped word among them
    for (int i = 0; i < 24; i++) begin
      k = $unsigned($random(seed)) % 6;
      d = $random(seed);
      wr_reg(amap[k], d);
      rd_reg(amap[k], v);
      chk(v, rb_exp(amap[k], d));
    end
    wr_reg(OFF_ROW, 32'h0);
    rd_reg(OFF_ROW, v);
    chk(v, 32'hff);
    wr_reg(OFF_DIVIDER, 32'h0);
    col_w = 32'h0;
    wr_reg(OFF_COLUMN, col_w);
    wr_reg(OFF_IRQ_MASK, 32'h3);
    idle(8);
    rd_reg(OFF_STATUS, v);
    // One-cycle contact bounce must be filtered out
    keys[5] = 1'b1;
    idle(1);
    keys[5] = 1'b0;
    idle(12);
    chk({31'h0, irq}, 32'h0);
    // Every enable combination, press then release
    for (int m = 0; m < 4; m++) begin
      wr_reg(OFF_CONTROL, m);
      rd_reg(OFF_STATUS, v);
      k = $unsigned($random(seed)) % 64;
      keys[k] = 1'b1;
      wait_irq(12, n);
      chk({31'h0, irq}, m & 1);
      rd_reg(OFF_ROW, v);
      chk(v, rows_exp(keys, col_w));
      rd_reg(OFF_STATUS, v);
      chk(v, m & 1);
      chk({31'h0, irq}, 32'h0);
      keys[k] = 1'b0;
      wait_irq(12, n);
      rd_reg(OFF_STATUS, v);
      chk(v, m & 2);
    end
    wr_reg(OFF_IRQ_MASK, 32'h0);
    keys[9] = 1'b1;
    idle(12);
    chk({31'h0, irq}, 32'h0);
    rd_reg(OFF_STATUS, v);
    chk(v, 32'h1);
    keys[9] = 1'b0;
    wr_reg(OFF_IRQ_MASK, 32'h3);
    idle(12);
    rd_reg(OFF_STATUS, v);
    rd_reg(OFF_STATUS, v);
    chk(v, 32'h0);
    // Slower filter ticks stretch the settle time
    d = 2 + $unsigned($random(seed)) % 4;
    wr_reg(OFF_DIVIDER, d);
    keys[20] = 1'b1;
    wait_irq(40, n);
    chk(32'(n >= d + 3 && n <= 2 * d + 3), 32'h1);
    keys[$unsigned($random(seed)) % 64] = 1'b1;
    // Software scan: one column driven low at a time
    for (int c = 0; c < 8; c++) begin
      col_w = {16'h0, ~(8'h1 << c), 8'h0};
      wr_reg(OFF_COLUMN, col_w);
      rd_reg(OFF_ROW, v);
      chk(v, rows_exp(keys, col_w));
      chk({24'h0, col_oe}, {24'h0, ~col_w[15:8]});
      chk({24'h0, col_out}, {24'h0, col_w[7:0]});
    end
    end_of_test();
  end

  // Watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge clk_sys);
    failures++;
    end_of_test();
  end
endmodule
